// File: inc/spo_defines.svh
// constants for the speed pulse output configuration block
`ifndef SPO_DEFINES_SVH
`define SPO_DEFINES_SVH
`define SPO_CFG_ADDR 12'h088
`define SPO_CFG_RESET 32'h0000_0000
`define SPO_RDATA_IDLE 32'h0000_0000
`define SPO_SEL_HI 30
`define SPO_SEL_LO 29
`define SPO_DIV_HI 28
`define SPO_DIV_LO 25
`define SPO_THR_HI 23
`define SPO_THR_LO 21
`define SPO_DIV_ZERO_VAL 4'h3
`define SPO_THR_RESV 3'h6
`define SPO_MV_1 5'h01
`define SPO_MV_2 5'h02
`define SPO_MV_5 5'h05
`define SPO_MV_10 5'h0A
`define SPO_MV_20 5'h14
`define SPO_MV_30 5'h1E
`endif

// File: inc/spo_pkg.sv
// types for the speed pulse output configuration block
package spo_pkg;
    typedef enum logic [1:0] {
        SPO_MODE_BOTH = 2'b00,
        SPO_MODE_CLOSED = 2'b01,
        SPO_MODE_FIRST = 2'b10,
        SPO_MODE_RESV = 2'b11
    } spo_mode_type;
    typedef struct packed {
        logic [31:0] cfg;
        logic [31:0] rdata;
        logic err;
    } spo_regs_type;
    typedef struct packed {
        logic [3:0] cnt;
        logic pulse;
        logic prev_in;
    } spo_div_type;
endpackage

// File: rtl/spo_divider.sv
// divides commutation events down to a toggling speed pulse
`timescale 1ns/10ps
`include "spo_defines.svh"
module spo_divider
    import spo_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // control
    input wire logic [3:0] div_code,
    input wire logic enable,
    input wire logic commutation_evt,
    // output
    output logic pulse_out
);
    spo_div_type st_ff;
    spo_div_type nxt_st;
    logic [3:0] div_val;

    always_comb begin
        div_val = (div_code == 4'h0) ? `SPO_DIV_ZERO_VAL : div_code;
        nxt_st = st_ff;
        nxt_st.prev_in = commutation_evt;
        if (!enable) begin
            nxt_st.cnt = 4'h0;
            nxt_st.pulse = 1'b0;
        end else if (commutation_evt && !st_ff.prev_in) begin
            if (st_ff.cnt >= div_val - 4'h1) begin
                nxt_st.cnt = 4'h0;
                nxt_st.pulse = ~st_ff.pulse;
            end else begin
                nxt_st.cnt = st_ff.cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    assign pulse_out = st_ff.pulse;
endmodule

// File: rtl/spo_config.sv
// speed pulse output configuration register and output gating
`timescale 1ns/10ps
`include "spo_defines.svh"
module spo_config
    import spo_pkg::*;
(
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // motor control status
    input wire logic commutation_evt,
    input wire logic closed_loop,
    input wire logic open_loop,
    input wire logic first_attempt,
    // outputs
    output logic speed_pulse_output,
    output logic [4:0] pulse_backemf_threshold,
    output logic threshold_valid
);
    // register state
    spo_regs_type st_ff;
    spo_regs_type nxt_st;
    // apb phase decode
    logic hit;
    logic setup_phase;
    logic access_phase;
    logic wr_accept;
    logic err_next;
    logic [31:0] rd_word;
    // configuration fields
    spo_mode_type pulse_output_mode_select;
    logic [3:0] pulse_division_factor;
    logic [2:0] thr_code;
    // output gating
    logic open_ok;
    logic closed_ok;
    logic active;
    logic pulse_raw;
    // threshold decode
    logic [4:0] thr_mv;
    logic thr_ok;

    // apb phase decode
    assign hit = (paddr == `SPO_CFG_ADDR);
    assign setup_phase = psel && !penable;
    assign access_phase = psel && penable;
    assign wr_accept = access_phase && pwrite && hit;
    assign err_next = setup_phase && !hit;

    // configuration fields
    assign pulse_output_mode_select = spo_mode_type'(st_ff.cfg[`SPO_SEL_HI:`SPO_SEL_LO]);
    assign pulse_division_factor = st_ff.cfg[`SPO_DIV_HI:`SPO_DIV_LO];
    assign thr_code = st_ff.cfg[`SPO_THR_HI:`SPO_THR_LO];

    // read word chosen in the setup phase
    always_comb begin
        if (hit && !pwrite) begin
            rd_word = st_ff.cfg;
        end else begin
            rd_word = `SPO_RDATA_IDLE;
        end
    end

    // register and read path next state
    always_comb begin
        nxt_st = st_ff;
        nxt_st.err = err_next;
        if (setup_phase) begin
            nxt_st.rdata = rd_word;
        end
        if (wr_accept) begin
            nxt_st.cfg = pwdata;
        end
    end

    // control phase qualification
    always_comb begin
        open_ok = 1'b0;
        closed_ok = 1'b0;
        case (pulse_output_mode_select)
            SPO_MODE_BOTH: begin
                open_ok = open_loop;
                closed_ok = closed_loop;
            end
            SPO_MODE_CLOSED: begin
                open_ok = 1'b0;
                closed_ok = closed_loop;
            end
            SPO_MODE_FIRST: begin
                open_ok = open_loop && first_attempt;
                closed_ok = closed_loop;
            end
            default: begin
                open_ok = 1'b0;
                closed_ok = 1'b0;
            end
        endcase
    end

    assign active = open_ok || closed_ok;

    // back-emf threshold decode
    always_comb begin
        thr_mv = `SPO_MV_1;
        thr_ok = 1'b1;
        case (thr_code)
            3'h0: begin
                thr_mv = `SPO_MV_1;
            end
            3'h1: begin
                thr_mv = `SPO_MV_2;
            end
            3'h2: begin
                thr_mv = `SPO_MV_5;
            end
            3'h3: begin
                thr_mv = `SPO_MV_10;
            end
            3'h4: begin
                thr_mv = `SPO_MV_20;
            end
            3'h5: begin
                thr_mv = `SPO_MV_30;
            end
            default: begin
                thr_mv = `SPO_MV_1;
                thr_ok = 1'b0;
            end
        endcase
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '{cfg: `SPO_CFG_RESET, rdata: `SPO_RDATA_IDLE, err: 1'b0};
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    // commutation divider
    spo_divider u_spo_divider (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .div_code(pulse_division_factor),
        .enable(active),
        .commutation_evt(commutation_evt),
        .pulse_out(pulse_raw)
    );

    // bus and pulse outputs
    assign prdata = st_ff.rdata;
    assign pready = access_phase && clk_en;
    assign pslverr = access_phase && st_ff.err;
    assign speed_pulse_output = pulse_raw;
    assign pulse_backemf_threshold = thr_mv;
    assign threshold_valid = thr_ok;
endmodule

// File: tb/spo_chk.sv
// assertion checker on the speed pulse configuration ports
`timescale 1ns/10ps
module spo_chk(
    input wire logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, closed_loop, open_loop,
    input wire logic first_attempt, speed_pulse_output, threshold_valid,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic [4:0] pulse_backemf_threshold
);
    logic [31:0] cfg_ff;
    wire a = psel && penable && clk_en;
    wire [1:0] m = cfg_ff[30:29];
    wire [2:0] t = cfg_ff[23:21];
    wire off = m == 2'h3 || !closed_loop && (m == 2'h1 || !open_loop || m == 2'h2 && !first_attempt);
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) cfg_ff <= 32'h0;
        else if (a && pwrite && paddr == 12'h088) cfg_ff <= pwdata;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_now: assert property (pready == a) else $error("ready");
    chk_err_unmapped: assert property (a |-> pslverr == (paddr != 12'h088)) else $error("err");
    chk_read_data: assert property (a && !pwrite |-> prdata == (paddr == 12'h088 ? cfg_ff : 0)) else $error("rd");
    chk_gate_off: assert property (clk_en && off |=> !speed_pulse_output) else $error("gate");
    chk_thr_low: assert property (t == 3'h0 |-> pulse_backemf_threshold == 5'h01) else $error("t0");
    chk_thr_mid: assert property (t == 3'h3 |-> pulse_backemf_threshold == 5'h0A) else $error("t3");
    chk_thr_top: assert property (t == 3'h5 |-> pulse_backemf_threshold == 5'h1E) else $error("t5");
    chk_thr_resv: assert property (threshold_valid == (t < 3'h6)) else $error("tv");
endmodule

// File: tb/spo_host.sv
// host model counting speed pulse edges
`timescale 1ns/10ps
module spo_host(
    input wire logic pclk,
    input wire logic speed_pulse_output,
    output int edges
);
    logic last_ff = 1'b0;
    initial edges = 0;
    always @(posedge pclk) begin
        if (speed_pulse_output !== last_ff) edges <= edges + 1;
        last_ff <= speed_pulse_output;
    end
endmodule

// File: tb/spo_config_tb.sv
// self-checking bench for the speed pulse configuration block
`timescale 1ns/10ps
module spo_config_tb;
    logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0, commutation_evt = 0;
    logic closed_loop = 0, open_loop = 0, first_attempt = 0, pready, pslverr, speed_pulse_output, threshold_valid;
    logic [11:0] paddr = 12'h000, ua;
    logic [31:0] pwdata = 32'h0, prdata, rd, wd;
    logic [4:0] pulse_backemf_threshold;
    logic [4:0] mv [8] = '{5'h01, 5'h02, 5'h05, 5'h0A, 5'h14, 5'h1E, 5'h01, 5'h01};
    int n_mismatch = 0, check_count = 0, cyc = 0, edges, base;
    spo_config u_spo_config(.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .commutation_evt(commutation_evt), .closed_loop(closed_loop), .open_loop(open_loop),
        .first_attempt(first_attempt), .speed_pulse_output(speed_pulse_output),
        .pulse_backemf_threshold(pulse_backemf_threshold), .threshold_valid(threshold_valid));
    spo_host u_spo_host(.pclk(pclk), .speed_pulse_output(speed_pulse_output), .edges(edges));
    initial forever #5 pclk = ~pclk;
    always @(posedge pclk) if (++cyc == 12000) begin n_mismatch++; end_of_test(); end
    function int ndiv(input logic [3:0] c); return c == 4'h0 ? 3 : c; endfunction
    function int exp_tg(input logic [3:0] k);
        return (k[1:0] == 0 || k[1:0] == 1 && k[3] || k[1:0] == 2 && (k[3] || k[2])) ? 3 : 0;
    endfunction
    task check(input string nm, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin n_mismatch++; $display("mismatch %s exp %h seen %h", nm, exp, seen); end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk) penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        {psel, penable} <= 2'b00;
    endtask
    task ev(input int n);
        repeat (n) begin
            @(posedge pclk) commutation_evt <= 1;
            repeat (2) @(posedge pclk);
            commutation_evt <= 0;
            @(posedge pclk);
        end
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h1066B364));
        repeat (12) @(posedge pclk);
        presetn <= 1;
        apb(0, 12'h088, 0, rd); check("reset", rd, 32'h0);
        ua = {10'($urandom_range(35, 1023)), 2'b00};
        apb(1, ua, $urandom, rd);
        apb(0, ua, 0, rd); check("unmapped", rd, 32'h0);
        for (int k = 0; k < 16; k++) begin
            {open_loop, closed_loop} <= 2'b00;
            repeat (3) @(posedge pclk);
            base = edges;
            wd = {1'($urandom), k[1:0], k[3:0], 1'b1, k[2:0], 21'($urandom)};
            apb(1, 12'h088, wd, rd);
            apb(0, 12'h088, 0, rd); check("cfg", rd, wd);
            check("thr", pulse_backemf_threshold, mv[k[2:0]]);
            check("valid", threshold_valid, k[2:0] < 6);
            {open_loop, closed_loop, first_attempt} <= {1'b1, k[3], k[2]};
            ev(3 * ndiv(k[3:0]));
            repeat (4) @(posedge pclk);
            check("pulses", edges - base, exp_tg(k[3:0]));
        end
        // divider changed while pulses run, no restart
        {open_loop, closed_loop} <= 2'b10;
        apb(1, 12'h088, 32'h0400_0000, rd);
        ev(3);
        apb(1, 12'h088, 32'h0220_0000, rd);
        base = edges;
        ev(2);
        repeat (4) @(posedge pclk);
        check("live div", edges - base, 2);
        // clock enable low freezes the divider
        base = edges;
        clk_en <= 0;
        ev(2);
        clk_en <= 1;
        ev(1);
        repeat (4) @(posedge pclk);
        check("freeze", edges - base, 1);
        // reset in mid-run
        presetn <= 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        check("rst pulse", speed_pulse_output, 0);
        check("rst thr", pulse_backemf_threshold, 5'h01);
        apb(0, 12'h088, 0, rd); check("rst cfg", rd, 32'h0);
        end_of_test();
    end
endmodule
bind spo_config spo_chk u_spo_chk(.*);
